// File: verilog/tws_params.svh
// Purpose: offsets, fields, codes and reset values of the slave receiver
// Assumes: 32-bit apb data, byte addresses
// Notes:   definitions only
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define TWS_OFF_CTRL     8'h00
`define TWS_OFF_STAT     8'h04
`define TWS_OFF_DATA     8'h08
`define TWS_OFF_ADDR     8'h0c
`define TWS_OFF_ISTAT    8'h10
`define TWS_OFF_IEN      8'h14
`define TWS_OFF_ICLR     8'h18
// ----------------------------------------
// bus_control fields
// ----------------------------------------
`define TWS_CB_DONE      7
`define TWS_CB_ACKEN     6
`define TWS_CB_STA       5
`define TWS_CB_STO       4
`define TWS_CB_WCOL      3
`define TWS_CB_EN        2
`define TWS_CB_IE        0
// ----------------------------------------
// status codes
// ----------------------------------------
`define TWS_ST_OWN       8'h60
`define TWS_ST_OWN_ARB   8'h68
`define TWS_ST_GC        8'h70
`define TWS_ST_GC_ARB    8'h78
`define TWS_ST_DAT_ACK   8'h80
`define TWS_ST_DAT_NACK  8'h88
`define TWS_ST_GCD_ACK   8'h90
`define TWS_ST_GCD_NACK  8'h98
`define TWS_ST_STOP      8'ha0
`define TWS_ST_NONE      8'hf8
// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define TWS_RST_BYTE     8'h00
`define TWS_RST_IRQ      3'h0
`define TWS_BITS         4'h8
`endif

// File: verilog/tws_pkg.sv
// Purpose: types of the slave receiver
// Assumes: nothing
// Notes:   gray codes along the receive path
`default_nettype none
package tws_pkg;
  typedef enum logic [2:0] {
    TWS_IDLE = 3'b000,
    TWS_ADDR = 3'b001,
    TWS_AACK = 3'b011,
    TWS_DATA = 3'b010,
    TWS_DACK = 3'b110
  } tws_state_t;
endpackage : tws_pkg
`default_nettype wire

// File: verilog/tws_slave_rx.sv
// Purpose: two-wire slave receiver with apb registers
// Assumes: pclk 100 MHz, bus pins sampled by pclk
// Notes:   open-drain pins, oe low drives low
// Behaviour
// - answer when upper seven address bits match own address
// - answer general call 0x00 only when own address bit 0 is one
// - after own address, write bit enters receive, read is not answered
// - own address with write sets done flag and valid status
// - addressed after lost arbitration reports 0x68 or 0x78
// - ack enable cleared gives not-acknowledge after next data byte
// - ack enable zero ignores own address, bus still watched
// - in deep sleep own or general call still acknowledged
// - sleeping match raises wake, scl held low until flag cleared
// - data register not loaded by address bytes after wake
// - own write address acked reports 0x60, next byte per ack enable
// - lost arbitration then own write address reports 0x68
// - general call acked reports 0x70
// - lost arbitration then general call reports 0x78
// - acked data under own address reports 0x80, byte held
// - nacked data reports 0x88, then not addressed
// - start request in not addressed drives start once bus free
`include "tws_params.svh"
`default_nettype none
module tws_slave_rx
  import tws_pkg::*;
(
  input  wire logic        pclk,      // system clock
  input  wire logic        presetn,   // async reset, low
  input  wire logic        psel,      // apb select
  input  wire logic        penable,   // apb access phase
  input  wire logic        pwrite,    // apb direction
  input  wire logic [7:0]  paddr,     // apb byte address
  input  wire logic [31:0] pwdata,    // apb write data
  output logic      [31:0] prdata,    // apb read data
  output logic             pready,    // apb ready
  output logic             pslverr,   // apb error
  input  wire logic        scl_i,     // scl level
  output logic             scl_o,     // scl drive value
  output logic             scl_oe_n,  // scl drive, low
  input  wire logic        sda_i,     // sda level
  output logic             sda_o,     // sda drive value
  output logic             sda_oe_n,  // sda drive, low
  input  wire logic        arb_lost,  // master lost arbitration pulse
  input  wire logic        sleep_i,   // deep sleep active
  output logic             wake_o,    // wake request
  output logic             start_gen, // start to be sent
  output logic             irq        // interrupt, high
);
  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic own_hit(input logic [7:0] a, input logic [7:0] own);
    own_hit = (a[7:1] == own[7:1]);
  endfunction : own_hit
  function automatic logic gc_hit(input logic [7:0] a, input logic [7:0] own);
    gc_hit = (a[7:1] == 7'h00) && own[0];
  endfunction : gc_hit

  // ----------------------------------------
  // pin synchronisers and bus events
  // ----------------------------------------
  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic       scl_rise, scl_fall, start_det, stop_det;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
    end else begin
      scl_s <= {scl_s[1:0], scl_i};
      sda_s <= {sda_s[1:0], sda_i};
    end
  end

  assign scl_rise  = scl_s[1] & ~scl_s[2];
  assign scl_fall  = ~scl_s[1] & scl_s[2];
  assign start_det = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
  assign stop_det  = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];

  // ----------------------------------------
  // registers and apb decode
  // ----------------------------------------
  tws_state_t  state_q;
  logic [3:0]  cnt_q;
  logic [7:0]  shr_q;
  logic [7:0]  data_q;
  logic [7:0]  stat_q;
  logic [7:0]  own_q;
  logic        flag_q, ack_en_q, sta_q, sto_q, wcol_q, en_q, ie_q;
  logic        gc_q, arb_q, acked_q, hold_q, wake_q, busy_q, sda_drv_q;
  logic [2:0]  istat_q;
  logic [2:0]  ien_q;
  logic [31:0] rdata_q;
  logic        wr, mapped, sw_clr, byte_end, ack_end;
  logic        addressed, addr_ok, ev_stopa, ev_done;
  logic [2:0]  ev_irq;
  assign wr       = psel & penable & pwrite;
  assign mapped   = (paddr == `TWS_OFF_CTRL) || (paddr == `TWS_OFF_STAT) ||
                    (paddr == `TWS_OFF_DATA) || (paddr == `TWS_OFF_ADDR) ||
                    (paddr == `TWS_OFF_ISTAT) || (paddr == `TWS_OFF_IEN) ||
                    (paddr == `TWS_OFF_ICLR);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~mapped;
  assign prdata   = rdata_q;
  assign sw_clr   = wr & mapped & (paddr == `TWS_OFF_CTRL) & pwdata[`TWS_CB_DONE];

  assign byte_end = scl_fall & (cnt_q == `TWS_BITS);
  assign ack_end  = scl_fall & ((state_q == TWS_AACK) | (state_q == TWS_DACK));
  assign addressed = (state_q == TWS_AACK) | (state_q == TWS_DATA) | (state_q == TWS_DACK);
  // match, write direction, ack enabled, interface enabled
  assign addr_ok  = (own_hit(shr_q, own_q) | gc_hit(shr_q, own_q)) & ~shr_q[0] &
                    ack_en_q & en_q;
  assign ev_stopa = addressed & (stop_det | start_det);
  assign ev_done  = ack_end | ev_stopa;
  assign ev_irq   = {wr & (paddr == `TWS_OFF_DATA) & ~flag_q,
                     (state_q == TWS_ADDR) & byte_end & addr_ok & sleep_i,
                     ev_done};

  // ----------------------------------------
  // receive state machine
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= TWS_IDLE;
    end else if (!en_q || stop_det) begin
      state_q <= TWS_IDLE;
    end else if (start_det) begin
      state_q <= TWS_ADDR;
    end else begin
      case (state_q)
        TWS_IDLE: state_q <= TWS_IDLE;
        TWS_ADDR: begin
          if (byte_end) begin
            state_q <= addr_ok ? TWS_AACK : TWS_IDLE;
          end
        end
        TWS_AACK: if (scl_fall) state_q <= TWS_DATA;
        TWS_DATA: if (byte_end) state_q <= TWS_DACK;
        TWS_DACK: begin
          if (scl_fall) begin
            state_q <= acked_q ? TWS_DATA : TWS_IDLE;
          end
        end
        default: state_q <= TWS_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // bit counter and shift register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
      shr_q <= `TWS_RST_BYTE;
    end else if (start_det || ack_end) begin
      cnt_q <= 4'h0;
    end else if (scl_rise && cnt_q != `TWS_BITS) begin
      cnt_q <= cnt_q + 4'h1;
      shr_q <= {shr_q[6:0], sda_s[1]};
    end
  end

  // ----------------------------------------
  // acknowledge drive
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_drv_q <= 1'b0;
      acked_q   <= 1'b0;
      gc_q      <= 1'b0;
      arb_q     <= 1'b0;
    end else begin
      if (arb_lost) begin
        arb_q <= 1'b1;
      end else if (start_det || stop_det) begin
        arb_q <= arb_q & (state_q == TWS_IDLE);
      end
      if (ack_end || ev_stopa || !en_q) begin
        sda_drv_q <= 1'b0;
      end else if (byte_end && state_q == TWS_ADDR) begin
        sda_drv_q <= addr_ok;
        gc_q      <= ~own_hit(shr_q, own_q);
      end else if (byte_end && state_q == TWS_DATA) begin
        sda_drv_q <= ack_en_q;
        acked_q   <= ack_en_q;
      end
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_n = ~sda_drv_q;
  assign scl_o    = 1'b0;
  assign scl_oe_n = ~hold_q;

  // ----------------------------------------
  // done flag, status, data, stretch
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
      hold_q <= 1'b0;
      stat_q <= `TWS_ST_NONE;
    end else begin
      if (ev_done) begin
        flag_q <= 1'b1;
      end else if (sw_clr) begin
        flag_q <= 1'b0;
      end
      if (ack_end) begin
        hold_q <= 1'b1;
      end else if (sw_clr || ev_stopa) begin
        hold_q <= 1'b0;
      end
      if (ev_stopa) begin
        stat_q <= `TWS_ST_STOP;
      end else if (ack_end && state_q == TWS_AACK) begin
        case ({gc_q, arb_q})
          2'b00:   stat_q <= `TWS_ST_OWN;
          2'b01:   stat_q <= `TWS_ST_OWN_ARB;
          2'b10:   stat_q <= `TWS_ST_GC;
          default: stat_q <= `TWS_ST_GC_ARB;
        endcase
      end else if (ack_end) begin
        case ({gc_q, acked_q})
          2'b01:   stat_q <= `TWS_ST_DAT_ACK;
          2'b00:   stat_q <= `TWS_ST_DAT_NACK;
          2'b11:   stat_q <= `TWS_ST_GCD_ACK;
          default: stat_q <= `TWS_ST_GCD_NACK;
        endcase
      end else if (sw_clr) begin
        stat_q <= `TWS_ST_NONE;
      end
    end
  end

  // only received data bytes and apb writes while the flag is set reach the data register, never address bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q <= `TWS_RST_BYTE;
    end else if (byte_end && state_q == TWS_DATA) begin
      data_q <= shr_q;
    end else if (wr && paddr == `TWS_OFF_DATA && flag_q) begin
      data_q <= pwdata[7:0];
    end
  end

  // ----------------------------------------
  // wake, bus busy, start generation
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_q    <= 1'b0;
      busy_q    <= 1'b0;
      start_gen <= 1'b0;
    end else begin
      if (ev_irq[1]) begin
        wake_q <= 1'b1;
      end else if (sw_clr) begin
        wake_q <= 1'b0;
      end
      if (start_det) begin
        busy_q <= 1'b1;
      end else if (stop_det) begin
        busy_q <= 1'b0;
      end
      start_gen <= (state_q == TWS_IDLE) & sta_q & en_q & ~busy_q & ~flag_q;
    end
  end

  assign wake_o = wake_q;
  // ----------------------------------------
  // software registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_en_q <= 1'b0;
      sta_q    <= 1'b0;
      sto_q    <= 1'b0;
      en_q     <= 1'b0;
      ie_q     <= 1'b0;
      own_q    <= `TWS_RST_BYTE;
    end else if (wr && paddr == `TWS_OFF_CTRL) begin
      ack_en_q <= pwdata[`TWS_CB_ACKEN];
      sta_q    <= pwdata[`TWS_CB_STA];
      sto_q    <= pwdata[`TWS_CB_STO];
      en_q     <= pwdata[`TWS_CB_EN];
      ie_q     <= pwdata[`TWS_CB_IE];
    end else if (wr && paddr == `TWS_OFF_ADDR) begin
      own_q    <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wcol_q <= 1'b0;
    end else if (ev_irq[2]) begin
      wcol_q <= 1'b1;
    end else if (sw_clr) begin
      wcol_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // interrupt status, enable, clear
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_q <= `TWS_RST_IRQ;
      ien_q   <= `TWS_RST_IRQ;
    end else begin
      // set wins over a clear in the same cycle
      istat_q <= (istat_q & ~((wr && paddr == `TWS_OFF_ICLR) ? pwdata[2:0] : 3'h0)) | ev_irq;
      if (wr && paddr == `TWS_OFF_IEN) begin
        ien_q <= pwdata[2:0];
      end
    end
  end

  assign irq = ie_q & (|(istat_q & ien_q));

  // ----------------------------------------
  // read data, latched in the setup phase
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (paddr)
        `TWS_OFF_CTRL:  rdata_q <= {24'h0, flag_q, ack_en_q, sta_q, sto_q, wcol_q, en_q, 1'b0, ie_q};
        `TWS_OFF_STAT:  rdata_q <= {24'h0, stat_q};
        `TWS_OFF_DATA:  rdata_q <= {24'h0, data_q};
        `TWS_OFF_ADDR:  rdata_q <= {24'h0, own_q};
        `TWS_OFF_ISTAT: rdata_q <= {29'h0, istat_q};
        `TWS_OFF_IEN:   rdata_q <= {29'h0, ien_q};
        default:        rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_addr_end;
    state_q == TWS_ADDR && byte_end && !start_det && !stop_det && en_q;
  endsequence
  sequence s_data_end;
    state_q == TWS_DATA && byte_end && !start_det && !stop_det && en_q;
  endsequence
  a_own_addr_ack: assert property (@(posedge pclk) disable iff (!presetn)
    s_addr_end ##0 (own_hit(shr_q, own_q) && !shr_q[0] && ack_en_q) |=>
      state_q == TWS_AACK && !sda_oe_n)
    else $error("own write address not acknowledged");
  a_gc_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    s_addr_end ##0 (shr_q[7:1] == 7'h00 && !own_q[0] && own_q[7:1] != 7'h00) |=>
      state_q == TWS_IDLE && sda_oe_n)
    else $error("general call answered while disabled");
  a_no_ack_disabled: assert property (@(posedge pclk) disable iff (!presetn)
    s_addr_end ##0 !ack_en_q |=> state_q == TWS_IDLE && sda_oe_n)
    else $error("address acknowledged with ack enable low");
  a_addr_status: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == TWS_AACK && scl_fall && !stop_det && !start_det && en_q) |=>
      flag_q && !scl_oe_n && stat_q[7:4] inside {4'h6, 4'h7} && stat_q[2:0] == 3'h0)
    else $error("no valid status after address");
  a_gc_status: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == TWS_AACK && scl_fall && gc_q && !arb_q && !ev_stopa) |=> stat_q == `TWS_ST_GC)
    else $error("general call status wrong");
  a_nack_data: assert property (@(posedge pclk) disable iff (!presetn)
    s_data_end ##0 !ack_en_q |=> !acked_q && sda_oe_n)
    else $error("data byte acknowledged with ack enable low");
  a_nack_status: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == TWS_DACK && scl_fall && !acked_q && !start_det && !stop_det && en_q) |=>
      stat_q == (gc_q ? `TWS_ST_GCD_NACK : `TWS_ST_DAT_NACK) && state_q == TWS_IDLE)
    else $error("nack path status or state wrong");
  a_data_held: assert property (@(posedge pclk) disable iff (!presetn)
    s_data_end |=> data_q == $past(shr_q))
    else $error("received byte not stored");
  a_scl_stretch: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(flag_q) && !scl_oe_n ##0 (!sw_clr && !ev_stopa)[*2] |=> !scl_oe_n && flag_q)
    else $error("scl released while flag set");
  a_sleep_wake: assert property (@(posedge pclk) disable iff (!presetn)
    s_addr_end ##0 (addr_ok && sleep_i) |=> wake_o ##1 (wake_o || $past(sw_clr)))
    else $error("no wake on sleeping match");
  a_start_free: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == TWS_IDLE && sta_q && en_q && !busy_q && !flag_q) |=> start_gen)
    else $error("start not requested on free bus");

endmodule : tws_slave_rx
`default_nettype wire

// File: tb/tws_bus_master.sv
// Purpose: two-wire bus master transmitter beside the slave receiver
// Assumes: pull-ups on both lines, 80 ns link period stepped by pclk
// Notes:   pulls lines low only, waits out an scl stretch of up to 300 pclk cycles
`default_nettype none
module tws_bus_master (
  input  wire logic pclk,   // bench clock
  input  wire logic scl,    // scl wire level
  input  wire logic sda,    // sda wire level
  output logic      scl_dn, // pull scl low
  output logic      sda_dn  // pull sda low
);
  timeunit 1ns;
  timeprecision 1ps;
  int hang_cnt = 0;
  initial begin
    scl_dn = 1'b0;
    sda_dn = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  // release scl, then wait while the slave holds it low
  task automatic scl_high();
    int n;
    n = 0;
    scl_dn <= 1'b0;
    do begin
      tick(1);
      n++;
    end while (scl !== 1'b1 && n < 300);
    if (n >= 300) begin
      hang_cnt++;
    end
    tick(2);
  endtask : scl_high
  task automatic start();
    sda_dn <= 1'b0;
    scl_dn <= 1'b0;
    tick(4);
    sda_dn <= 1'b1;
    tick(4);
    scl_dn <= 1'b1;
    tick(2);
  endtask : start
  task automatic bit_out(input logic b, output logic s);
    sda_dn <= ~b;
    tick(2);
    scl_high();
    s = sda;
    tick(1);
    scl_dn <= 1'b1;
    tick(2);
  endtask : bit_out
  // msb first, ninth clock reads the acknowledge
  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_out(b[i], s);
    end
    bit_out(1'b1, s);
    ack = ~s;
  endtask : write_byte
  task automatic stop();
    sda_dn <= 1'b1;
    tick(2);
    scl_high();
    tick(2);
    sda_dn <= 1'b0;
    tick(4);
  endtask : stop
endmodule : tws_bus_master
`default_nettype wire

// File: tb/tb_top.sv
// Purpose: self-checking bench of the two-wire slave receiver
// Assumes: apb master here, bus master partner, pull-ups on both lines
// Notes:   reference state in the _m variables predicts the acknowledge and status results
`include "tws_params.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals and reference state
  // ----------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, arb_lost, sleep_i, scl_dn, sda_dn;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, scl_o, scl_oe_n, sda_o, sda_oe_n, wake_o, start_gen, irq;
  wire         scl_w, sda_w;
  logic [6:0]  own_m;
  bit          gce_m, acken_m, sta_m, ie_m, arb_m, addr_m, gc_m;
  int          error_cnt, compares, seed;
  assign scl_w = !(scl_dn || (!scl_oe_n && !scl_o));
  assign sda_w = !(sda_dn || (!sda_oe_n && !sda_o));
  tws_slave_rx tws_slave_rx_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .arb_lost(arb_lost), .sleep_i(sleep_i), .wake_o(wake_o), .start_gen(start_gen), .irq(irq));
  tws_bus_master tws_bus_master_inst (.pclk(pclk), .scl(scl_w), .sda(sda_w), .scl_dn(scl_dn), .sda_dn(sda_dn));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #900us;
    error_cnt++;
    end_of_test();
  end
  // ----------------------------------------
  // checks, bus cycles, model
  // ----------------------------------------
  task automatic end_of_test();
    error_cnt += tws_bus_master_inst.hang_cnt;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_reg
  task automatic chk_bit(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 20) begin
      error_cnt++;
      end_of_test();
    end
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input string nm);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk_reg(nm, x, r);
  endtask : rd_chk
  function automatic logic [31:0] ctrl_w(input bit done);
    return {24'h0, done, acken_m, sta_m, 3'b001, 1'b0, ie_m};
  endfunction : ctrl_w
  function automatic logic [7:0] exp_addr(input logic [7:0] b);
    if (!acken_m || b[0]) return 8'h00;
    if (b[7:1] == own_m) return arb_m ? `TWS_ST_OWN_ARB : `TWS_ST_OWN;
    if (b == 8'h00 && gce_m) return arb_m ? `TWS_ST_GC_ARB : `TWS_ST_GC;
    return 8'h00;
  endfunction : exp_addr
  task automatic clr();
    wr(`TWS_OFF_CTRL, ctrl_w(1'b1));
    tws_bus_master_inst.tick(2);
    chk_bit("scl free", 1'b1, scl_oe_n);
  endtask : clr
  task automatic addr_txn(input logic [7:0] b, input bit arb);
    logic       ack;
    logic [7:0] e;
    arb_m = arb;
    e = exp_addr(b);
    tws_bus_master_inst.start();
    arb_lost <= arb;
    @(posedge pclk);
    arb_lost <= 1'b0;
    tws_bus_master_inst.write_byte(b, ack);
    chk_bit("addr ack", e != 8'h00, ack);
    tws_bus_master_inst.tick(8);
    rd_chk(`TWS_OFF_STAT, (e != 8'h00) ? e : `TWS_ST_NONE, "status");
    if (e != 8'h00) begin
      chk_bit("scl stretch", 1'b0, scl_oe_n);
      chk_bit("wake", sleep_i, wake_o);
      addr_m = 1'b1;
      gc_m = (b == 8'h00);
    end
    arb_m = 1'b0;
  endtask : addr_txn
  task automatic data_txn(input logic [7:0] b, input bit next_acken);
    logic ack;
    bit   ea;
    ea = acken_m;
    tws_bus_master_inst.write_byte(b, ack);
    chk_bit("data ack", ea, ack);
    tws_bus_master_inst.tick(8);
    rd_chk(`TWS_OFF_STAT, gc_m ? (ea ? `TWS_ST_GCD_ACK : `TWS_ST_GCD_NACK) :
           (ea ? `TWS_ST_DAT_ACK : `TWS_ST_DAT_NACK), "status");
    if (ea) begin
      rd_chk(`TWS_OFF_DATA, {24'h0, b}, "data");
    end
    addr_m = ea;
    acken_m = next_acken;
    clr();
  endtask : data_txn
  task automatic end_seq();
    tws_bus_master_inst.stop();
    tws_bus_master_inst.tick(8);
    if (addr_m) begin
      rd_chk(`TWS_OFF_STAT, `TWS_ST_STOP, "status");
      clr();
    end
    addr_m = 1'b0;
  endtask : end_seq
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] r;
    logic        e;
    presetn = 1'b0;
    {psel, penable, pwrite, arb_lost, sleep_i} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    seed = $urandom(32'hb751a996);
    own_m = 7'($urandom_range(127, 2));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd_chk(`TWS_OFF_STAT, `TWS_ST_NONE, "status");
    chk_bit("irq", 1'b0, irq);
    chk_bit("start", 1'b0, start_gen);
    apb(1'b0, 8'h1c, 32'h0, r, e);
    chk_bit("pslverr", 1'b1, e);
    chk_reg("unmapped", 32'h0, r);
    $display("test reset done");
    {gce_m, acken_m, ie_m, sta_m} = 4'b1110;
    wr(`TWS_OFF_ADDR, {24'h0, own_m, gce_m});
    rd_chk(`TWS_OFF_ADDR, {24'h0, own_m, gce_m}, "own addr");
    wr(`TWS_OFF_IEN, 32'h7);
    wr(`TWS_OFF_CTRL, ctrl_w(1'b0));
    addr_txn({own_m ^ 7'h01, 1'b0}, 1'b0);
    end_seq();
    addr_txn({own_m, 1'b1}, 1'b0);
    end_seq();
    $display("test refuse done");
    addr_txn({own_m, 1'b0}, 1'b0);
    chk_bit("irq", 1'b1, irq);
    clr();
    wr(`TWS_OFF_ICLR, 32'h7);
    chk_bit("irq", 1'b0, irq);
    data_txn(8'($urandom), 1'b1);
    data_txn(8'($urandom), 1'b0);
    sta_m = 1'b1;
    data_txn(8'($urandom), 1'b1);
    end_seq();
    chk_bit("start", 1'b1, start_gen);
    sta_m = 1'b0;
    wr(`TWS_OFF_CTRL, ctrl_w(1'b0));
    tws_bus_master_inst.tick(2);
    chk_bit("start", 1'b0, start_gen);
    $display("test own done");
    acken_m = 1'b0;
    wr(`TWS_OFF_CTRL, ctrl_w(1'b0));
    addr_txn({own_m, 1'b0}, 1'b0);
    end_seq();
    acken_m = 1'b1;
    wr(`TWS_OFF_CTRL, ctrl_w(1'b0));
    addr_txn({own_m, 1'b0}, 1'b0);
    clr();
    data_txn(8'($urandom), 1'b1);
    end_seq();
    addr_txn(8'h00, 1'b0);
    clr();
    data_txn(8'($urandom), 1'b1);
    end_seq();
    gce_m = 1'b0;
    wr(`TWS_OFF_ADDR, {24'h0, own_m, gce_m});
    addr_txn(8'h00, 1'b0);
    end_seq();
    gce_m = 1'b1;
    wr(`TWS_OFF_ADDR, {24'h0, own_m, gce_m});
    $display("test ackctl done");
    addr_txn({own_m, 1'b0}, 1'b1);
    clr();
    end_seq();
    addr_txn(8'h00, 1'b1);
    clr();
    end_seq();
    $display("test arb done");
    wr(`TWS_OFF_ICLR, 32'h7);
    wr(`TWS_OFF_IEN, 32'h0);
    sleep_i <= 1'b1;
    addr_txn({own_m, 1'b0}, 1'b0);
    chk_bit("irq masked", 1'b0, irq);
    rd_chk(`TWS_OFF_ISTAT, 32'h3, "irq status");
    sleep_i <= 1'b0;
    clr();
    chk_bit("wake", 1'b0, wake_o);
    data_txn(8'($urandom), 1'b1);
    end_seq();
    $display("test sleep done");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
